// ---- lptc_defines.svh ----
/*
 * Shared constants for the low power timer trigger/mode core.
 * Assumes inclusion by bare name from the core file.
 */
`ifndef LPTC_DEFINES_SVH
`define LPTC_DEFINES_SVH

`define LPTC_TRIG_SOFTWARE    2'h0
`define LPTC_TRIG_RISE        2'h1
`define LPTC_TRIG_FALL        2'h2
`define LPTC_TRIG_BOTH        2'h3
`define LPTC_EDGE_RISE        2'h0
`define LPTC_EDGE_FALL        2'h1
`define LPTC_EDGE_BOTH        2'h2
`define LPTC_ENABLE_DELAY     2'h2
`define LPTC_TRIG_DELAY       2'h2
`define LPTC_SW_DELAY         2'h3
`define LPTC_PIN_CFG_EDGES    2'h3
`define LPTC_XFER_STAGES      2'h2
`define LPTC_COUNT_ZERO       16'h0000
`define LPTC_COUNT_ONE        16'h0001

`endif

// ---- lptc_pkg.sv ----
/*
 * Types of the low power timer core.
 * Assumes lptc_defines.svh is on the include path.
 */
`default_nettype none
package lptc_pkg;
    typedef enum logic [1:0] {
        LPTC_IDLE,
        LPTC_ARMED,
        LPTC_DELAY,
        LPTC_RUN
    } lptc_state_type;
endpackage
`default_nettype wire

// ---- lptc_core.sv ----
/*
 * Low power timer core: trigger select, single/continuous counting,
 * single-set, retrigger timeout, output polarity, reload/compare update.
 * Assumes all control inputs are synchronous to clock; one-cycle pulses
 * on continuous_start/single_start/write strobes.
 */
`timescale 1ns/1ps
`include "lptc_defines.svh"
`default_nettype none

// Contract
// - Three-bit select picks one of eight triggers
// - Polarity field chooses software or edge start
// - Single mode stops and flags at reload
// - Triggers ignored while single run active
// - Single-set starts once, later triggers discarded
// - Software single start runs exactly once
// - Continuous mode wraps at reload, flags match
// - First trigger starts continuous, rest ignored
// - Single start switches continuous to single
// - Continuous start switches single to continuous
// - Retrigger timeout restarts count from zero
// - Compare match event when count reaches compare
// - PWM in continuous, pulse/set in single
// - Polarity inverts output immediately, sets idle level
// - Buffered update loads values at reload match
// - Write-done flags low while value crosses
// - Internal clock or sampled pin edges counted
// - Edge select chooses rise, fall or both
// - Pin-only clock counts one edge kind
// - Pin-clocked core counts from fourth edge
// - Two count clocks after activate before counting
// - Starts written while disabled are dropped
// - Two count clock delay after trigger
// - Software start begins three core clocks later
module lptc_core
    import lptc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Configuration
    input  wire logic             core_activate,
    input  wire logic [2:0]       trigger_source_select,
    input  wire logic [1:0]       trigger_enable_polarity,
    input  wire logic             single_set_select,
    input  wire logic             retrigger_timeout_enable,
    input  wire logic             output_polarity,
    input  wire logic             buffered_update,
    input  wire logic             external_clock_only,
    input  wire logic             pin_count_mode,
    input  wire logic [1:0]       count_edge_select,
    // Software strobes
    input  wire logic             continuous_start,
    input  wire logic             single_start,
    input  wire logic             reload_write,
    input  wire logic [WIDTH-1:0] reload_wdata,
    input  wire logic             compare_write,
    input  wire logic [WIDTH-1:0] compare_wdata,
    // Trigger sources
    input  wire logic             external_trigger_pin,
    input  wire logic             rtc_alarm_first,
    input  wire logic             rtc_alarm_second,
    input  wire logic             rtc_wakeup,
    input  wire logic             rtc_timestamp,
    input  wire logic             dedicated_trigger_pin,
    input  wire logic             voltage_comparator_one,
    input  wire logic             voltage_comparator_two,
    // Count pin
    input  wire logic             count_input_pin,
    // Status
    output logic [WIDTH-1:0]      count_value,
    output logic                  reload_match_flag,
    output logic                  compare_match_flag,
    output logic                  reload_write_done,
    output logic                  compare_write_done,
    output logic                  running,
    output logic                  wave_out
);

    // ----------------------------------------------------------------
    // Trigger selection and edge detect
    // ----------------------------------------------------------------
    logic [7:0] trig_vec;
    logic       trig_sel;
    logic       trig_prev_q;
    logic       trig_event;
    logic       pin_prev_q;
    logic       pin_rise;
    logic       pin_fall;
    logic       tick;

    assign trig_vec = {voltage_comparator_two, voltage_comparator_one, dedicated_trigger_pin,
                       rtc_timestamp, rtc_wakeup, rtc_alarm_second, rtc_alarm_first,
                       external_trigger_pin};
    assign trig_sel = trig_vec[trigger_source_select];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            trig_prev_q <= 1'b0;
            pin_prev_q  <= 1'b0;
        end else begin
            trig_prev_q <= trig_sel;
            pin_prev_q  <= count_input_pin;
        end
    end

    always_comb begin
        case (trigger_enable_polarity)
            `LPTC_TRIG_RISE: trig_event = trig_sel & ~trig_prev_q;
            `LPTC_TRIG_FALL: trig_event = ~trig_sel & trig_prev_q;
            `LPTC_TRIG_BOTH: trig_event = trig_sel ^ trig_prev_q;
            default:         trig_event = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Count clock tick
    // ----------------------------------------------------------------
    // Pin-only clocking is modelled as sampled edges; both-edge setting
    // falls back to rising since that clock can only use one edge.
    assign pin_rise = count_input_pin & ~pin_prev_q;
    assign pin_fall = ~count_input_pin & pin_prev_q;

    always_comb begin
        if (external_clock_only) begin
            tick = (count_edge_select == `LPTC_EDGE_FALL) ? pin_fall : pin_rise;
        end else if (pin_count_mode) begin
            case (count_edge_select)
                `LPTC_EDGE_FALL: tick = pin_fall;
                `LPTC_EDGE_BOTH: tick = pin_rise | pin_fall;
                default:         tick = pin_rise;
            endcase
        end else begin
            tick = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Enable delay and pin-clock configuration edges
    // ----------------------------------------------------------------
    logic [1:0] en_cnt_q;
    logic       en_ready;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            en_cnt_q <= 2'h0;
        end else if (!core_activate) begin
            en_cnt_q <= 2'h0;
        end else if (tick && !en_ready) begin
            en_cnt_q <= en_cnt_q + 2'h1;
        end
    end
    assign en_ready = external_clock_only ? (en_cnt_q == `LPTC_PIN_CFG_EDGES)
                                          : (en_cnt_q >= `LPTC_ENABLE_DELAY);

    // ----------------------------------------------------------------
    // Mode and start control
    // ----------------------------------------------------------------
    logic           cont_mode_q;
    logic           armed_q;
    logic           set_done_q;
    logic [1:0]     dly_q;
    logic           sw_mode;
    lptc_state_type state_q;
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] reload_q;
    logic [WIDTH-1:0] compare_q;
    logic           at_reload;
    logic           start_wr;

    assign sw_mode   = (trigger_enable_polarity == `LPTC_TRIG_SOFTWARE);
    assign start_wr  = core_activate & (continuous_start | single_start);
    assign at_reload = (state_q == LPTC_RUN) && tick && (cnt_q == reload_q);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cont_mode_q <= 1'b0;
        end else if (start_wr) begin
            cont_mode_q <= continuous_start;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= LPTC_IDLE;
            dly_q      <= 2'h0;
            armed_q    <= 1'b0;
            set_done_q <= 1'b0;
        end else if (!core_activate) begin
            state_q    <= LPTC_IDLE;
            dly_q      <= 2'h0;
            armed_q    <= 1'b0;
            set_done_q <= 1'b0;
        end else begin
            case (state_q)
                LPTC_IDLE: begin
                    if (start_wr) begin
                        armed_q <= 1'b1;
                        if (sw_mode) begin
                            state_q <= LPTC_DELAY;
                            dly_q   <= `LPTC_SW_DELAY - 2'h1;
                        end else begin
                            state_q <= LPTC_ARMED;
                        end
                    end
                end
                LPTC_ARMED: begin
                    // Single-set allows only the first trigger after activation
                    if (trig_event && !(single_set_select && set_done_q)) begin
                        state_q    <= LPTC_DELAY;
                        dly_q      <= `LPTC_TRIG_DELAY - 2'h1;
                        set_done_q <= 1'b1;
                    end
                end
                LPTC_DELAY: begin
                    // Delay is in count ticks; software start delay is core clocks
                    if (sw_mode || tick) begin
                        if (dly_q == 2'h0) begin
                            if (en_ready) begin
                                state_q <= LPTC_RUN;
                            end
                        end else begin
                            dly_q <= dly_q - 2'h1;
                        end
                    end
                end
                LPTC_RUN: begin
                    if (at_reload && !cont_mode_q) begin
                        // triggers only rearm after stop
                        state_q <= (sw_mode || single_set_select) ? LPTC_IDLE : LPTC_ARMED;
                    end
                end
                default: state_q <= LPTC_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    logic retrig;
    assign retrig = retrigger_timeout_enable && !sw_mode && trig_event;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= `LPTC_COUNT_ZERO;
        end else if (!core_activate || state_q != LPTC_RUN) begin
            cnt_q <= `LPTC_COUNT_ZERO;
        end else if (retrig) begin
            cnt_q <= `LPTC_COUNT_ZERO;
        end else if (at_reload) begin
            cnt_q <= `LPTC_COUNT_ZERO;
        end else if (tick && en_ready) begin
            cnt_q <= cnt_q + `LPTC_COUNT_ONE;
        end
    end

    // Match flags are held until activation drops; set wins over clear.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reload_match_flag  <= 1'b0;
            compare_match_flag <= 1'b0;
        end else begin
            reload_match_flag  <= at_reload | (reload_match_flag & core_activate);
            compare_match_flag <= ((state_q == LPTC_RUN) && tick && (cnt_q == compare_q))
                                  | (compare_match_flag & core_activate);
        end
    end

    // ----------------------------------------------------------------
    // Reload and compare update with crossing delay
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] reload_pend_q;
    logic [WIDTH-1:0] compare_pend_q;
    logic [1:0]       reload_xfer_q;
    logic [1:0]       compare_xfer_q;
    logic             reload_wait_q;
    logic             compare_wait_q;
    logic             buf_hold;

    // Buffered values wait for the reload match only while counting
    assign buf_hold = buffered_update && (state_q == LPTC_RUN);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reload_pend_q <= `LPTC_COUNT_ZERO;
            reload_xfer_q <= 2'h0;
            reload_wait_q <= 1'b0;
            reload_q      <= `LPTC_COUNT_ZERO;
        end else if (reload_write) begin
            reload_pend_q <= reload_wdata;  // overwrite mid-update is undefined
            reload_xfer_q <= `LPTC_XFER_STAGES;
            reload_wait_q <= 1'b1;
        end else if (reload_xfer_q != 2'h0) begin
            reload_xfer_q <= reload_xfer_q - 2'h1;
        end else if (reload_wait_q && (!buf_hold || at_reload)) begin
            reload_q      <= reload_pend_q;
            reload_wait_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            compare_pend_q <= `LPTC_COUNT_ZERO;
            compare_xfer_q <= 2'h0;
            compare_wait_q <= 1'b0;
            compare_q      <= `LPTC_COUNT_ZERO;
        end else if (compare_write) begin
            compare_pend_q <= compare_wdata;
            compare_xfer_q <= `LPTC_XFER_STAGES;
            compare_wait_q <= 1'b1;
        end else if (compare_xfer_q != 2'h0) begin
            compare_xfer_q <= compare_xfer_q - 2'h1;
        end else if (compare_wait_q && (!buf_hold || at_reload)) begin
            compare_q      <= compare_pend_q;
            compare_wait_q <= 1'b0;
        end
    end

    assign reload_write_done  = ~reload_wait_q;
    assign compare_write_done = ~compare_wait_q;

    // ----------------------------------------------------------------
    // Output waveform
    // ----------------------------------------------------------------
    logic wave_raw_q;

    // PWM / single pulse: high from compare to reload; single-set stays set
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wave_raw_q <= 1'b0;
        end else if (!core_activate) begin
            wave_raw_q <= 1'b0;
        end else if (state_q == LPTC_RUN) begin
            if (at_reload && !(single_set_select && !cont_mode_q)) begin
                wave_raw_q <= 1'b0;
            end else if (tick && cnt_q >= compare_q) begin
                wave_raw_q <= 1'b1;
            end
        end
    end

    // Polarity applied after the flop so a change shows at once
    assign wave_out    = wave_raw_q ^ output_polarity;
    assign count_value = cnt_q;
    assign running     = (state_q == LPTC_RUN);

endmodule // lptc_core
`default_nettype wire

// ---- lptc_core_sva.sv ----
/* Port checker for lptc_core.
   Assumes a bind onto every lptc_core instance. */
`timescale 1ns/1ps
`default_nettype none
module lptc_core_sva #(
    parameter int WIDTH = 16
) (
    // Clock, reset and controls
    input wire logic             clock,
    input wire logic             rst_b,
    input wire logic             core_activate,
    input wire logic [1:0]       trigger_enable_polarity,
    input wire logic             pin_count_mode,
    input wire logic             external_clock_only,
    input wire logic             retrigger_timeout_enable,
    input wire logic             output_polarity,
    input wire logic             buffered_update,
    // Strobes
    input wire logic             continuous_start,
    input wire logic             single_start,
    input wire logic             reload_write,
    input wire logic             compare_write,
    // Status
    input wire logic [WIDTH-1:0] count_value,
    input wire logic             reload_match_flag,
    input wire logic             compare_match_flag,
    input wire logic             reload_write_done,
    input wire logic             compare_write_done,
    input wire logic             running,
    input wire logic             wave_out
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    disabled_clear_a : assert property (
        !core_activate |=> !running && count_value == '0)
        else $error("timer active while disabled");
    // Pin ticks gate the enable delay, so pin counting is left out here
    sw_start_delay_a : assert property (
        $rose(running) && trigger_enable_polarity == 2'h0 && !external_clock_only
        && !pin_count_mode
        |-> $past(single_start, 4) || $past(continuous_start, 4))
        else $error("software start latency wrong");
    match_zero_a : assert property (
        $rose(reload_match_flag) |-> count_value == '0)
        else $error("count not zero at reload match");
    flag_sticky_a : assert property (
        reload_match_flag && core_activate |=> reload_match_flag)
        else $error("reload match flag dropped");
    count_step_a : assert property (
        running && $past(running) && !pin_count_mode && !external_clock_only
        && !retrigger_timeout_enable
        |-> count_value == $past(count_value) + 1'b1 || count_value == '0)
        else $error("internal count step wrong");
    reload_done_a : assert property (
        reload_write && !buffered_update
        |=> !reload_write_done [*3] ##1 reload_write_done)
        else $error("reload write done timing wrong");
    compare_done_a : assert property (
        compare_write && !buffered_update
        |=> !compare_write_done [*3] ##1 compare_write_done)
        else $error("compare write done timing wrong");
    idle_level_a : assert property (
        !core_activate && !$past(core_activate) |-> wave_out == output_polarity)
        else $error("idle output level wrong");

    sw_run_c : cover property ($rose(running) && trigger_enable_polarity == 2'h0);
    trig_run_c : cover property ($rose(running) && trigger_enable_polarity != 2'h0);
    cmp_hit_c : cover property ($rose(compare_match_flag));
endmodule // lptc_core_sva

bind lptc_core lptc_core_sva #(.WIDTH(WIDTH)) u_sva (.*);
`default_nettype wire

// ---- lptc_far_model.sv ----
/* Far side of lptc_core: eight trigger sources and the count pin.
   Assumes bench requests change on the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module lptc_far_model (
    // Clock
    input  wire logic       clock,
    // Requests
    input  wire logic [2:0] trig_sel,
    input  wire logic       trig_level,
    input  wire logic       pin_run,
    // Lines into the timer
    output var  logic [7:0] trig_lines,
    output var  logic       pin_line
);
    logic [7:0] noise;

    initial begin
        trig_lines = 8'h00;
        pin_line = 1'b0;
    end

    // Unselected lines chatter so a wrong select shows up
    always @(negedge clock) begin
        #1;
        noise = 8'($urandom);
        noise[trig_sel] = trig_level;
        trig_lines = noise;
        // One change per clock at most keeps every edge visible
        if (pin_run) begin
            pin_line = !pin_line;
        end
    end
endmodule // lptc_far_model
`default_nettype wire

// ---- lptc_core_tb_top.sv ----
/* Self-checking bench for lptc_core.
   Assumes the package, checker and far-side model compile first. */
`timescale 1ns/1ps
`default_nettype none
module lptc_core_tb_top;
    import lptc_pkg::*;
    // ------
    // Signals
    // ------
    logic        clock, rst_b, core_activate, single_set_select, output_polarity;
    logic        retrigger_timeout_enable, buffered_update, external_clock_only;
    logic        pin_count_mode, continuous_start, single_start, reload_write;
    logic        compare_write, trig_level, pin_run, count_input_pin, running;
    logic        reload_match_flag, compare_match_flag, wave_out;
    logic        reload_write_done, compare_write_done;
    logic [1:0]  trigger_enable_polarity, count_edge_select;
    logic [2:0]  trigger_source_select;
    logic [7:0]  trig_lines;
    logic [15:0] reload_wdata, compare_wdata, count_value;
    int          failures, n_tests, n, r, c0;

    lptc_far_model far (.clock(clock), .trig_sel(trigger_source_select),
        .trig_level(trig_level), .pin_run(pin_run), .trig_lines(trig_lines),
        .pin_line(count_input_pin));
    lptc_core #(.WIDTH(16)) uut (.*, .external_trigger_pin(trig_lines[0]),
        .rtc_alarm_first(trig_lines[1]), .rtc_alarm_second(trig_lines[2]),
        .rtc_wakeup(trig_lines[3]), .rtc_timestamp(trig_lines[4]),
        .dedicated_trigger_pin(trig_lines[5]), .voltage_comparator_one(trig_lines[6]),
        .voltage_comparator_two(trig_lines[7]));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ------
    // Tasks
    // ------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        n = 0;
        while (s !== 1'b1) begin
            if (n == lim) begin
                failures++;
                $display("timeout after %0d cycles", lim);
                complete_run();
            end
            cyc(1);
            n++;
        end
    endtask
    // Pokes the trigger twice mid-run when asked
    task automatic run_len(input logic poke);
        n = 0;
        while (running === 1'b1 && n < 400) begin
            if (poke && (n == 2 || n == 5))
                trig_level = !trig_level;
            cyc(1);
            n++;
        end
    endtask
    // Configuration only changes while the core is off
    task automatic setup(input logic [1:0] pol, input logic [2:0] src,
                         input logic [3:0] opt, input logic [1:0] ces);
        core_activate = 1'b0;
        cyc(2);
        trigger_enable_polarity = pol;
        trigger_source_select = src;
        {single_set_select, retrigger_timeout_enable, pin_count_mode,
         external_clock_only} = opt;
        count_edge_select = ces;
        cyc(1);
        core_activate = 1'b1;
        cyc(4);
    endtask
    task automatic wr(input logic cmp, input logic [15:0] v);
        if (cmp) begin
            compare_wdata = v;
            pulse(compare_write);
            cyc(1);
            wait_hi(compare_write_done, 8);
        end else begin
            reload_wdata = v;
            pulse(reload_write);
            cyc(1);
            wait_hi(reload_write_done, 8);
        end
    endtask
    // ------
    // Sequence
    // ------
    initial begin
        {core_activate, single_set_select, output_polarity, retrigger_timeout_enable} = 4'h0;
        {buffered_update, external_clock_only, pin_count_mode, continuous_start} = 4'h0;
        {single_start, reload_write, compare_write, trig_level, pin_run} = 5'h00;
        {trigger_enable_polarity, count_edge_select, trigger_source_select} = 7'h00;
        {reload_wdata, compare_wdata} = 32'h0000_0000;
        failures = 0;
        n_tests = 0;
        rst_b = 1'b0;
        void'($urandom(32'heeff_655f));
        repeat (5) @(posedge clock);
        @(negedge clock) rst_b = 1'b1;
        chk("reset done", 1, reload_write_done & compare_write_done);
        for (int p = 0; p < 2; p++) begin
            output_polarity = p[0];
            #1 chk("idle wave", p[0], wave_out);
        end
        output_polarity = 1'b0;
        $display("end of reset test");
        r = 2 + $urandom % 20;
        setup(2'h0, 3'h0, 4'h0, 2'h0);
        wr(1'b0, r[15:0]);
        pulse(single_start);
        cyc(2);
        chk("early run", 0, running);
        cyc(1);
        chk("sw start", 1, running);
        run_len(1'b0);
        chk("single length", 16'(r + 1), n[15:0]);
        chk("match flag", 1, reload_match_flag);
        chk("stop count", 0, count_value);
        core_activate = 1'b0;
        cyc(2);
        pulse(single_start);
        core_activate = 1'b1;
        cyc(8);
        chk("dropped start", 0, running);
        wr(1'b0, r[15:0]);
        pulse(continuous_start);
        cyc(3 * r + 8);
        chk("continuous", 1, running & reload_match_flag);
        pulse(single_start);
        run_len(1'b0);
        chk("stop after switch", 1, n <= r + 1);
        $display("end of software start tests");
        for (int s = 0; s < 8; s++) begin
            r = 8 + $urandom % 16;
            trig_level = (s % 3 == 1);
            setup(2'(1 + s % 3), 3'(s), 4'h0, 2'h0);
            wr(1'b0, r[15:0]);
            trig_level = !trig_level;
            cyc(3);
            trig_level = !trig_level;
            pulse(single_start);
            cyc(4);
            chk("unarmed or wrong source", 0, running);
            trig_level = !trig_level;
            wait_hi(running, 8);
            chk("trigger delay", 1, n >= 2);
            run_len(1'b1);
            chk("ignored retrigger", 16'(r + 1), n[15:0]);
            trig_level = !trig_level;
            cyc(2);
            trig_level = !trig_level;
            wait_hi(running, 8);
            run_len(1'b0);
            trig_level = !trig_level;
        end
        $display("end of trigger source tests");
        trig_level = 1'b0;
        setup(2'h1, 3'h5, 4'h8, 2'h0);
        wr(1'b0, 16'h000a);
        pulse(single_start);
        for (int k = 0; k < 2; k++) begin
            trig_level = 1'b1;
            cyc(6);
            chk("single set", k == 0, running);
            run_len(1'b0);
            trig_level = 1'b0;
            cyc(2);
        end
        $display("end of single set test");
        for (int t = 0; t < 2; t++) begin
            trig_level = 1'b0;
            setup(2'h3, 3'h2, {1'b0, t[0], 2'b00}, 2'h0);
            wr(1'b0, 16'h00c8);
            wr(1'b1, 16'h0032);
            pulse(continuous_start);
            trig_level = 1'b1;
            for (int k = 0; k < 4; k++) begin
                cyc(30);
                trig_level = !trig_level;
                cyc(6);
                chk("count cleared", t[0], count_value < 10);
                chk("early compare", 0, compare_match_flag & t[0]);
            end
            cyc(60);
            chk("timeout compare", 1, compare_match_flag);
            if (t[0]) begin
                chk("pwm level", 1, wave_out);
                output_polarity = 1'b1;
                #1 chk("pwm inverted", 0, wave_out);
                output_polarity = 1'b0;
            end
        end
        $display("end of timeout tests");
        for (int m = 0; m < 4; m++) begin
            setup(2'h0, 3'h0, {3'b001, m == 3}, 2'(m % 3));
            wr(1'b0, 16'hffff);
            pulse(continuous_start);
            for (int h = 0; h < 2; h++) begin
                c0 = count_value;
                pin_run = 1'b1;
                cyc(8);
                pin_run = 1'b0;
                cyc(6);
            end
            chk("pin edges", (m == 2) ? 8 : 4, count_value - c0[15:0]);
        end
        $display("end of pin count tests");
        buffered_update = 1'b1;
        setup(2'h0, 3'h0, 4'h0, 2'h0);
        wr(1'b0, 16'h0020);
        pulse(continuous_start);
        cyc(8);
        reload_wdata = 16'h0004;
        pulse(reload_write);
        cyc(8);
        chk("buffered hold", 0, reload_write_done);
        wait_hi(reload_write_done, 40);
        chk("buffered load", 0, count_value);
        buffered_update = 1'b0;
        $display("end of buffered update test");
        complete_run();
    end
endmodule // lptc_core_tb_top
`default_nettype wire
